// ### core/radio_ctrl_regs.svh
// Purpose: Fixed values and timing counts of the radio mode and synthesizer control core.
// Assumes: A 25 MHz system clock.
// Notes:   Definitions only.
`ifndef RADIO_CTRL_REGS_SVH
`define RADIO_CTRL_REGS_SVH

// ============================================================
// Synthesizer
`define FB_MULT        15'h04b
`define BAND_LAST      3'h5
`define BAND_RST       3'h0
`define SUBBAND_RST    2'h0

// ============================================================
// Queue limits and lock status reset
`define QUEUE_STEP_SH  4
`define LOCK_ST_RST    1'b0

// ============================================================
// On-off keying threshold tracking
`define PEAK_OFFSET    8'h10
`define AVG_SHIFT      3

// ============================================================
// Clock output divider, last count of each half period (half period is four system clocks)
`define CLOCK_OUT_PIN_HALF    4'h3

`endif

// ### core/radio_ctrl_pkg.sv
// Purpose: Types shared by the radio mode and synthesizer control core.
// Assumes: Nothing.
// Notes:   Constants live in radio_ctrl_regs.svh.
package radio_ctrl_pkg;

	typedef enum logic [2:0] {
		MODE_SLEEP,
		MODE_STANDBY,
		MODE_SYNTH,
		MODE_RX,
		MODE_TX
	} chip_mode_t;

	typedef struct packed {
		logic [7:0] ref_div;
		logic [7:0] fb_p;
		logic [7:0] fb_s;
	} divider_set_t;

	typedef struct packed {
		logic osc;
		logic synth;
		logic rx;
		logic tx;
	} func_enable_t;

	typedef struct packed {
		logic o;
		logic oe;
	} pin_drive_t;

endpackage : radio_ctrl_pkg

// ### core/bit_recovery.sv
// Purpose: Recovers a clean bit stream and bit clock from the raw demodulator bit and finds the start pattern.
// Assumes: raw_bit is already synchronised to mclk; bit_period is at least 4.
// Notes:   Data changes one system clock before the recovered clock rises.
`timescale 1ns/10ps
`default_nettype none

module bit_recovery (
	input  wire logic       mclk,
	input  wire logic       sys_rst,
	input  wire logic       raw_bit,
	input  wire logic       recovery_disable,
	input  wire logic       pattern_detect_enable,
	input  wire logic [7:0] bit_period,
	input  wire logic [7:0] start_pattern,
	output logic            rec_clock,
	output logic            rec_data,
	output logic            pattern_match
);

	logic [7:0] cnt_r, cnt_nxt;
	logic       raw_d_r;
	logic [7:0] shift_r, shift_nxt;
	logic       clk_nxt, data_nxt, match_nxt;
	logic [7:0] half;

	// ============================================================
	// Bit timing and pattern compare
	always_comb begin
		half      = bit_period >> 1;
		cnt_nxt   = cnt_r + 8'h01;
		clk_nxt   = rec_clock;
		data_nxt  = rec_data;
		shift_nxt = shift_r;
		match_nxt = pattern_match;
		if ((raw_bit != raw_d_r) || (cnt_r >= bit_period - 8'h01)) begin
			cnt_nxt = 8'h00;
		end
		if (recovery_disable) begin
			clk_nxt   = 1'b0;
			data_nxt  = raw_bit;
			match_nxt = 1'b0;
		end else if (cnt_r == 8'h00) begin
			clk_nxt = 1'b0;
		end else if (cnt_r == half) begin
			data_nxt = raw_bit;
		end else if (cnt_r == half + 8'h01) begin
			clk_nxt   = 1'b1;
			shift_nxt = {shift_r[6:0], rec_data};
			match_nxt = pattern_detect_enable && ({shift_r[6:0], rec_data} == start_pattern);
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			cnt_r         <= 8'h00;
			raw_d_r       <= 1'b0;
			shift_r       <= 8'h00;
			rec_clock     <= 1'b0;
			rec_data      <= 1'b0;
			pattern_match <= 1'b0;
		end else begin
			cnt_r         <= cnt_nxt;
			raw_d_r       <= raw_bit;
			shift_r       <= shift_nxt;
			rec_clock     <= clk_nxt;
			rec_data      <= data_nxt;
			pattern_match <= match_nxt;
		end
	end

	// ============================================================
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	sequence clk_rises;
		!rec_clock ##1 rec_clock;
	endsequence

	AST_RCLK_HELD_LOW: assert property (recovery_disable [*2] |-> !rec_clock)
		else $error("recovered clock not low while recovery disabled");
	AST_DATA_SETUP: assert property (clk_rises |-> $stable(rec_data))
		else $error("recovered data changed at recovered clock rise");
	AST_MATCH_ON_RISE: assert property (!$rose(rec_clock) && !$past(recovery_disable) |-> $stable(pattern_match))
		else $error("pattern match changed away from recovered clock rise");

endmodule : bit_recovery

`default_nettype wire

// ### core/radio_mode_synth_control.sv
// Purpose: Chip mode decode, pin states, divider set selection, lock status, queue thresholds and receive data path.
// Assumes: Queue byte count and serial read bits come from logic on mclk; pins and analog flags are asynchronous.
// Notes:   Every output is registered.
`timescale 1ns/10ps
`default_nettype none
`include "radio_ctrl_regs.svh"

module radio_mode_synth_control (
	input  wire logic                        mclk,
	input  wire logic                        sys_rst,
	input  wire logic [2:0]                  chip_level_mode,
	input  wire logic [2:0]                  band_select,
	input  wire logic [1:0]                  subband_select,
	input  wire radio_ctrl_pkg::divider_set_t divider_set_a,
	input  wire radio_ctrl_pkg::divider_set_t divider_set_b,
	input  wire logic                        divider_set_select,
	input  wire logic                        lock_pin_enable,
	input  wire logic                        lock_status_clear,
	input  wire logic                        pll_lock_raw,
	input  wire logic [1:0]                  data_handling_mode,
	input  wire logic [1:0]                  queue_length_select,
	input  wire logic [5:0]                  queue_level_threshold,
	input  wire logic [6:0]                  queue_count,
	input  wire logic                        recovery_disable,
	input  wire logic                        pattern_detect_enable,
	input  wire logic [7:0]                  start_pattern,
	input  wire logic [7:0]                  bit_period,
	input  wire logic                        onoff_select,
	input  wire logic [1:0]                  onoff_threshold_mode,
	input  wire logic [7:0]                  onoff_fixed_threshold,
	input  wire logic [7:0]                  signal_strength_value,
	input  wire logic                        fsk_raw_bit,
	input  wire logic                        config_select_n,
	input  wire logic                        data_select_n,
	input  wire logic                        config_read_bit,
	input  wire logic                        queue_read_bit,
	input  wire logic                        data_pin_i,
	output logic [2:0]                       band_code,
	output logic [1:0]                       subband_code,
	output logic [14:0]                      fb_ratio,
	output logic [8:0]                       ref_ratio,
	output radio_ctrl_pkg::func_enable_t     func_enable,
	output logic                             lock_pin,
	output logic                             lock_status_latch,
	output logic [6:0]                       queue_limit,
	output logic                             queue_full,
	output logic                             queue_not_empty,
	output logic                             rx_level_flag,
	output logic                             tx_level_flag,
	output logic                             tx_bit,
	output radio_ctrl_pkg::pin_drive_t       irq_line_zero,
	output radio_ctrl_pkg::pin_drive_t       irq_line_one,
	output radio_ctrl_pkg::pin_drive_t       clock_out_pin,
	output radio_ctrl_pkg::pin_drive_t       data_pin,
	output radio_ctrl_pkg::pin_drive_t       sdo_pin
);

	function automatic radio_ctrl_pkg::chip_mode_t decode_mode(input logic [2:0] code);
		case (code)
			3'h0:    decode_mode = radio_ctrl_pkg::MODE_SLEEP;
			3'h1:    decode_mode = radio_ctrl_pkg::MODE_STANDBY;
			3'h2:    decode_mode = radio_ctrl_pkg::MODE_SYNTH;
			3'h3:    decode_mode = radio_ctrl_pkg::MODE_RX;
			3'h4:    decode_mode = radio_ctrl_pkg::MODE_TX;
			default: decode_mode = radio_ctrl_pkg::MODE_SLEEP;
		endcase
	endfunction : decode_mode

	// ============================================================
	// Input synchronisers
	logic [4:0] sync1_r, sync2_r;
	logic       lock_s, demod_s, cfg_n_s, dat_n_s, pin_s;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			// Each stage resets to its pin's idle level, so release shows no false lock and no false edge.
			sync1_r <= 5'h06;
			sync2_r <= 5'h06;
		end else begin
			sync1_r <= {pll_lock_raw, fsk_raw_bit, config_select_n, data_select_n, data_pin_i};
			sync2_r <= sync1_r;
		end
	end
	assign {lock_s, demod_s, cfg_n_s, dat_n_s, pin_s} = sync2_r;

	// ============================================================
	// Mode, synthesizer, lock, queue and threshold state
	radio_ctrl_pkg::chip_mode_t   mode;
	radio_ctrl_pkg::divider_set_t act;
	radio_ctrl_pkg::func_enable_t en_nxt;
	logic [2:0]  band_nxt;
	logic [14:0] fb_nxt;
	logic [8:0]  ref_nxt;
	logic        lock_pin_nxt, lock_st_nxt;
	logic [6:0]  limit_nxt;
	logic        full_nxt, nempty_nxt, rxl_nxt, txl_nxt;

	always_comb begin
		mode      = decode_mode(chip_level_mode);
		act       = divider_set_select ? divider_set_b : divider_set_a;
		fb_nxt    = 15'(`FB_MULT * ({7'h00, act.fb_p} + 15'h0001)) + {7'h00, act.fb_s};
		ref_nxt   = {1'b0, act.ref_div} + 9'h001;
		band_nxt  = (band_select <= `BAND_LAST) ? band_select : band_code;
		en_nxt    = '0;
		case (mode)
			radio_ctrl_pkg::MODE_STANDBY: en_nxt = 4'b1000;
			radio_ctrl_pkg::MODE_SYNTH:   en_nxt = 4'b1100;
			radio_ctrl_pkg::MODE_RX:      en_nxt = 4'b1110;
			radio_ctrl_pkg::MODE_TX:      en_nxt = 4'b1101;
			default:                      en_nxt = 4'b0000;
		endcase
		lock_pin_nxt = lock_pin_enable && lock_s;
		lock_st_nxt  = lock_s || (lock_status_latch && !lock_status_clear);
		limit_nxt    = {3'(queue_length_select) + 3'h1, 4'h0};
		full_nxt     = queue_count >= limit_nxt;
		nempty_nxt   = queue_count != 7'h00;
		rxl_nxt      = queue_count >= {1'b0, queue_level_threshold};
		txl_nxt      = queue_count <= {1'b0, queue_level_threshold};
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			band_code         <= `BAND_RST;
			subband_code      <= `SUBBAND_RST;
			fb_ratio          <= 15'h0000;
			ref_ratio         <= 9'h001;
			func_enable       <= '0;
			lock_pin          <= 1'b0;
			lock_status_latch <= `LOCK_ST_RST;
			queue_limit       <= 7'h10;
			queue_full        <= 1'b0;
			queue_not_empty   <= 1'b0;
			rx_level_flag     <= 1'b0;
			tx_level_flag     <= 1'b0;
		end else begin
			band_code         <= band_nxt;
			subband_code      <= subband_select;
			fb_ratio          <= fb_nxt;
			ref_ratio         <= ref_nxt;
			func_enable       <= en_nxt;
			lock_pin          <= lock_pin_nxt;
			lock_status_latch <= lock_st_nxt;
			queue_limit       <= limit_nxt;
			queue_full        <= full_nxt;
			queue_not_empty   <= nempty_nxt;
			rx_level_flag     <= rxl_nxt;
			tx_level_flag     <= txl_nxt;
		end
	end

	// ============================================================
	// On-off keying threshold and raw demodulator bit
	logic [10:0] avg_acc_r, avg_acc_nxt;
	logic [7:0]  peak_r, peak_nxt, thr, avg;
	logic        raw_bit_r, raw_nxt;

	always_comb begin
		avg         = avg_acc_r[10:3];
		avg_acc_nxt = avg_acc_r - (avg_acc_r >> `AVG_SHIFT) + {3'h0, signal_strength_value};
		peak_nxt    = (signal_strength_value > peak_r) ? signal_strength_value : peak_r;
		if (mode != radio_ctrl_pkg::MODE_RX) begin
			peak_nxt = 8'h00;
		end
		case (onoff_threshold_mode)
			2'h0:    thr = onoff_fixed_threshold;
			2'h1:    thr = (peak_r > `PEAK_OFFSET) ? peak_r - `PEAK_OFFSET : 8'h00;
			2'h2:    thr = avg;
			default: thr = onoff_fixed_threshold;
		endcase
		raw_nxt = onoff_select ? (signal_strength_value >= thr) : demod_s;
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			avg_acc_r <= 11'h000;
			peak_r    <= 8'h00;
			raw_bit_r <= 1'b0;
		end else begin
			avg_acc_r <= avg_acc_nxt;
			peak_r    <= peak_nxt;
			raw_bit_r <= raw_nxt;
		end
	end

	// ============================================================
	// Data and clock recovery
	logic rec_clock, rec_data, pattern_match;

	bit_recovery u_rec (
		.mclk                  (mclk),
		.sys_rst               (sys_rst),
		.raw_bit               (raw_bit_r),
		.recovery_disable      (recovery_disable),
		.pattern_detect_enable (pattern_detect_enable),
		.bit_period            (bit_period),
		.start_pattern         (start_pattern),
		.rec_clock             (rec_clock),
		.rec_data              (rec_data),
		.pattern_match         (pattern_match)
	);

	// ============================================================
	// Pin drive
	logic [3:0] ck_cnt_r, ck_cnt_nxt;
	logic       ck_r, ck_nxt, cont, tx_bit_nxt;
	radio_ctrl_pkg::pin_drive_t irq_line_zero_nxt, irq_line_one_nxt, clko_nxt, data_nxt, sdo_nxt;

	always_comb begin
		cont       = data_handling_mode == 2'h0;
		ck_cnt_nxt = (ck_cnt_r == `CLOCK_OUT_PIN_HALF) ? 4'h0 : ck_cnt_r + 4'h1;
		ck_nxt     = (ck_cnt_r == `CLOCK_OUT_PIN_HALF) ? !ck_r : ck_r;
		irq_line_zero_nxt   = '{o: 1'b0, oe: 1'b1};
		irq_line_one_nxt   = '{o: queue_full, oe: 1'b1};
		clko_nxt   = '{o: ck_r, oe: 1'b1};
		data_nxt   = '{o: 1'b0, oe: 1'b0};
		tx_bit_nxt = tx_bit;
		case (mode)
			radio_ctrl_pkg::MODE_SLEEP: begin
				irq_line_zero_nxt = '{o: 1'b0, oe: 1'b0};
				irq_line_one_nxt = '{o: 1'b0, oe: 1'b0};
				clko_nxt = '{o: 1'b0, oe: 1'b0};
			end
			radio_ctrl_pkg::MODE_RX: begin
				data_nxt = '{o: cont ? rec_data : 1'b0, oe: 1'b1};
				irq_line_zero_nxt.o = cont ? pattern_match : rx_level_flag;
				if (cont) begin
					irq_line_one_nxt.o = rec_clock;
				end
			end
			radio_ctrl_pkg::MODE_TX: begin
				irq_line_zero_nxt.o = tx_level_flag;
				if (cont) begin
					tx_bit_nxt = pin_s;
				end
			end
			default: data_nxt = '{o: 1'b0, oe: 1'b0};
		endcase
		sdo_nxt.oe = !cfg_n_s || !dat_n_s;
		sdo_nxt.o  = !cfg_n_s ? config_read_bit : (!dat_n_s && queue_read_bit);
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			ck_cnt_r      <= 4'h0;
			ck_r          <= 1'b0;
			tx_bit        <= 1'b0;
			irq_line_zero <= '0;
			irq_line_one  <= '0;
			clock_out_pin <= '0;
			data_pin      <= '0;
			sdo_pin       <= '0;
		end else begin
			ck_cnt_r      <= ck_cnt_nxt;
			ck_r          <= ck_nxt;
			tx_bit        <= tx_bit_nxt;
			irq_line_zero <= irq_line_zero_nxt;
			irq_line_one  <= irq_line_one_nxt;
			clock_out_pin <= clko_nxt;
			data_pin      <= data_nxt;
			sdo_pin       <= sdo_nxt;
		end
	end

	// ============================================================
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	AST_LOCK_LATCH_SET: assert property (lock_s |=> lock_status_latch)
		else $error("lock status not set on lock");
	AST_LOCK_LATCH_HOLD: assert property (lock_status_latch && !lock_status_clear |=> lock_status_latch)
		else $error("lock status dropped without clear");
	AST_LOCK_PIN: assert property (lock_s && lock_pin_enable |=> lock_pin)
		else $error("lock pin low while locked and enabled");
	AST_SET_B: assert property (divider_set_select |=> ref_ratio == {1'b0, $past(divider_set_b.ref_div)} + 9'h001)
		else $error("reference ratio not from set b");
	AST_FB_RATIO: assert property (!divider_set_select |=>
		fb_ratio == 15'h004b * ({7'h00, $past(divider_set_a.fb_p)} + 15'h0001) + {7'h00, $past(divider_set_a.fb_s)})
		else $error("feedback ratio wrong");
	AST_SLEEP_FLOAT: assert property (chip_level_mode == 3'h0 |=>
		!irq_line_zero.oe && !irq_line_one.oe && !clock_out_pin.oe && !data_pin.oe)
		else $error("pin driven in sleep");
	AST_ENABLES: assert property (decode_mode(chip_level_mode) == radio_ctrl_pkg::MODE_RX |=> func_enable == 4'b1110)
		else $error("receive enables wrong");
	AST_SDO_CFG: assert property (!cfg_n_s |=> sdo_pin.oe && sdo_pin.o == $past(config_read_bit))
		else $error("serial out not from configuration");
	AST_QLIMIT: assert property (queue_length_select == 2'h2 |=> queue_limit == 7'h30)
		else $error("queue limit wrong");
	AST_RX_LEVEL: assert property (queue_count >= {1'b0, queue_level_threshold} |=> rx_level_flag)
		else $error("receive level flag missing");
	AST_TX_LEVEL: assert property (queue_count > {1'b0, queue_level_threshold} |=> !tx_level_flag)
		else $error("transmit level flag wrong");

endmodule : radio_mode_synth_control

`default_nettype wire

// ### verif/host_side_model.sv
// Purpose: Far side of the receive data path: feeds a 1-0 preamble and samples the recovered bit.
// Assumes: One bit lasts 320 ns, which is eight system clocks at the bench's bit_period.
// Notes:   The bit stream stands still while run is low.
`timescale 1ns/10ps
`default_nettype none

module host_side_model (
	input  wire logic mclk,
	input  wire logic run,
	input  wire logic rec_clock,
	input  wire logic rec_bit,
	output logic      raw_bit,
	output int        rise_count,
	output int        alt_errors
);
	logic last_bit;

	initial begin
		raw_bit    = 1'b0;
		last_bit   = 1'b0;
		rise_count = 0;
		alt_errors = 0;
		#7;
		forever begin
			#320;
			if (run) begin
				raw_bit = ~raw_bit;
			end
		end
	end

	// ============================================================
	// Sampling at the recovered clock's rising edge
	// After lock-in a preamble must come out as alternating bits.
	always @(posedge rec_clock) begin
		if (run) begin
			if (rise_count > 3 && rec_bit === last_bit) begin
				alt_errors = alt_errors + 1;
			end
			last_bit   = rec_bit;
			rise_count = rise_count + 1;
		end
	end
endmodule : host_side_model
`default_nettype wire

// ### verif/radio_mode_synth_control_tb.sv
// Purpose: Self-checking bench of the radio mode and synthesizer control core.
// Assumes: Inputs change at the falling edge; every output is registered.
// Notes:   The driver queues each expected value and a watcher compares it with the port.
`timescale 1ns/10ps
`default_nettype none

module radio_mode_synth_control_tb;
	typedef struct {
		string       nm;
		int          sel;
		logic [15:0] e;
	} note_t;

	logic mclk, sys_rst, divider_set_select, lock_pin_enable, lock_status_clear, pll_lock_raw;
	logic recovery_disable, pattern_detect_enable, onoff_select, config_select_n, data_select_n;
	logic config_read_bit, queue_read_bit, data_pin_i, run, raw_bit;
	logic [2:0] chip_level_mode, band_select, band_code;
	logic [1:0] subband_select, data_handling_mode, queue_length_select, onoff_threshold_mode, subband_code;
	logic [5:0] queue_level_threshold;
	logic [6:0] queue_count, queue_limit;
	logic [7:0] start_pattern, bit_period, onoff_fixed_threshold, signal_strength_value, rnd, p, s, r;
	logic [14:0] fb_ratio;
	logic [8:0]  ref_ratio;
	logic lock_pin, lock_status_latch, queue_full, queue_not_empty, rx_level_flag, tx_level_flag, tx_bit;
	radio_ctrl_pkg::divider_set_t divider_set_a, divider_set_b;
	radio_ctrl_pkg::func_enable_t func_enable;
	radio_ctrl_pkg::pin_drive_t   irq_line_zero, irq_line_one, clock_out_pin, data_pin, sdo_pin;
	int err_count, checks_done, rise_count, alt_errors;
	note_t notes[$];
	event  look;

	radio_mode_synth_control dut (.mclk(mclk), .sys_rst(sys_rst), .chip_level_mode(chip_level_mode),
		.band_select(band_select), .subband_select(subband_select), .divider_set_a(divider_set_a),
		.divider_set_b(divider_set_b), .divider_set_select(divider_set_select),
		.lock_pin_enable(lock_pin_enable), .lock_status_clear(lock_status_clear), .pll_lock_raw(pll_lock_raw),
		.data_handling_mode(data_handling_mode), .queue_length_select(queue_length_select),
		.queue_level_threshold(queue_level_threshold), .queue_count(queue_count),
		.recovery_disable(recovery_disable), .pattern_detect_enable(pattern_detect_enable),
		.start_pattern(start_pattern), .bit_period(bit_period), .onoff_select(onoff_select),
		.onoff_threshold_mode(onoff_threshold_mode), .onoff_fixed_threshold(onoff_fixed_threshold),
		.signal_strength_value(signal_strength_value), .fsk_raw_bit(raw_bit),
		.config_select_n(config_select_n), .data_select_n(data_select_n), .config_read_bit(config_read_bit),
		.queue_read_bit(queue_read_bit), .data_pin_i(data_pin_i), .band_code(band_code),
		.subband_code(subband_code), .fb_ratio(fb_ratio), .ref_ratio(ref_ratio), .func_enable(func_enable),
		.lock_pin(lock_pin), .lock_status_latch(lock_status_latch), .queue_limit(queue_limit),
		.queue_full(queue_full), .queue_not_empty(queue_not_empty), .rx_level_flag(rx_level_flag),
		.tx_level_flag(tx_level_flag), .tx_bit(tx_bit), .irq_line_zero(irq_line_zero),
		.irq_line_one(irq_line_one), .clock_out_pin(clock_out_pin), .data_pin(data_pin), .sdo_pin(sdo_pin));

	host_side_model partner (.mclk(mclk), .run(run), .rec_clock(irq_line_one.o), .rec_bit(data_pin.o),
		.raw_bit(raw_bit), .rise_count(rise_count), .alt_errors(alt_errors));

	initial mclk = 1'b0;
	always #20 mclk = ~mclk;

	// ============================================================
	// Helpers
	function automatic logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction : lfsr

	function automatic logic [15:0] obs(input int sel);
		case (sel)
			0: return {12'h000, func_enable};
			1: return {13'h0000, band_code};
			2: return {14'h0000, subband_code};
			3: return {1'b0, fb_ratio};
			4: return {7'h00, ref_ratio};
			5: return {14'h0000, lock_pin, lock_status_latch};
			6: return {9'h000, queue_limit};
			7: return {12'h000, queue_full, queue_not_empty, rx_level_flag, tx_level_flag};
			8: return {11'h000, irq_line_zero.oe, irq_line_one.oe, clock_out_pin.oe, data_pin.oe, sdo_pin.oe};
			9: return {14'h0000, sdo_pin};
			10: return {13'h0000, irq_line_zero.o, irq_line_one.o, data_pin.o};
			11: return {15'h0000, tx_bit};
			default: return {14'h0000, rise_count > 10, alt_errors == 0};
		endcase
	endfunction : obs

	task automatic chk(input string nm, input int sel, input logic [15:0] e);
		notes.push_back('{nm, sel, e});
		-> look;
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask : cyc

	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : results

	always @(look) begin
		note_t n;
		while (notes.size() > 0) begin
			n = notes.pop_front();
			checks_done = checks_done + 1;
			if (obs(n.sel) !== n.e) begin
				err_count = err_count + 1;
				$display("BAD %s expected %h seen %h", n.nm, n.e, obs(n.sel));
			end
		end
	end

	initial begin
		#2000000;
		err_count = err_count + 1;
		results();
	end

	// ============================================================
	// Main sequence
	initial begin
		logic [3:0]  fe_tab [6];
		logic [4:0]  oe_tab [6];
		logic [7:0]  ss_tab [6];
		logic [1:0]  om_tab [6];
		logic        ob_tab [6];
		logic [6:0]  cnt;
		logic [5:0]  thr;
		fe_tab = '{4'h0, 4'h8, 4'hc, 4'he, 4'hd, 4'h0};
		oe_tab = '{5'h00, 5'h1c, 5'h1c, 5'h1e, 5'h1c, 5'h00};
		ss_tab = '{8'hc8, 8'h0a, 8'hc8, 8'hbe, 8'h64, 8'h0a};
		om_tab = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h1, 2'h2};
		ob_tab = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
		err_count = 0; checks_done = 0; rnd = 8'h4f; run = 1'b0;
		sys_rst = 1'b1; chip_level_mode = 3'h0; band_select = 3'h0; subband_select = 2'h0;
		divider_set_a = '0; divider_set_b = '0; divider_set_select = 1'b0; lock_pin_enable = 1'b0;
		lock_status_clear = 1'b0; pll_lock_raw = 1'b0; data_handling_mode = 2'h0; queue_length_select = 2'h0;
		queue_level_threshold = 6'h00; queue_count = 7'h00; recovery_disable = 1'b0;
		pattern_detect_enable = 1'b0; start_pattern = 8'haa; bit_period = 8'h08; onoff_select = 1'b0;
		onoff_threshold_mode = 2'h0; onoff_fixed_threshold = 8'h32; signal_strength_value = 8'h00;
		config_select_n = 1'b1; data_select_n = 1'b1; config_read_bit = 1'b0; queue_read_bit = 1'b0;
		data_pin_i = 1'b0;
		cyc(12);
		chk("fe_rst", 0, 16'h0000);
		chk("limit_rst", 6, 16'h0010);
		chk("oe_rst", 8, 16'h0000);
		sys_rst = 1'b0;
		cyc(4);
		for (int m = 0; m < 6; m++) begin
			chip_level_mode = m[2:0];
			cyc(4);
			chk("func_enable", 0, {12'h000, fe_tab[m]});
			chk("pin_oe", 8, {11'h000, oe_tab[m]});
		end
		$display("test modes done");
		chip_level_mode = 3'h2;
		for (int b = 0; b < 8; b++) begin
			band_select = 3'(b % 6);
			subband_select = b[1:0];
			cyc(3);
			chk("band", 1, 16'(b % 6));
			chk("subband", 2, {14'h0000, b[1:0]});
		end
		$display("test bands done");
		// Hopping: the idle set is loaded, then the select flips.
		for (int i = 0; i < 8; i++) begin
			rnd = lfsr(rnd); p = rnd;
			rnd = lfsr(rnd); s = 8'(rnd % (p + 9'h001));
			rnd = lfsr(rnd); r = 8'h40 + 8'(rnd % 106);
			if (divider_set_select) divider_set_a = '{r, p, s};
			else divider_set_b = '{r, p, s};
			cyc(1);
			divider_set_select = ~divider_set_select;
			cyc(3);
			chk("fb_ratio", 3, 16'(8'h4b * (p + 16'h0001) + s));
			chk("ref_ratio", 4, 16'(r + 9'h001));
		end
		$display("test dividers done");
		pll_lock_raw = 1'b1; lock_pin_enable = 1'b1; cyc(6);
		chk("lock", 5, 16'h0003);
		lock_pin_enable = 1'b0; pll_lock_raw = 1'b0; cyc(6);
		chk("lock_held", 5, 16'h0001);
		lock_status_clear = 1'b1; cyc(2); lock_status_clear = 1'b0; cyc(2);
		chk("lock_clr", 5, 16'h0000);
		$display("test lock done");
		for (int l = 0; l < 4; l++) begin
			queue_length_select = l[1:0];
			cyc(3);
			chk("queue_limit", 6, 16'(16 * (l + 1)));
		end
		for (int i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			thr = 6'h01 + 6'(rnd % 62);
			queue_level_threshold = thr;
			for (int d = -1; d < 2; d++) begin
				cnt = 7'(thr + d);
				queue_count = (i == 3 && d == 1) ? 7'h40 : cnt;
				cyc(3);
				chk("queue_flags", 7, {12'h000, queue_count >= 7'h40, queue_count != 7'h00,
					queue_count >= {1'b0, thr}, queue_count <= {1'b0, thr}});
			end
		end
		$display("test queue done");
		chip_level_mode = 3'h1;
		for (int i = 0; i < 4; i++) begin
			{config_select_n, data_select_n, config_read_bit, queue_read_bit} = i[1] ?
				{~i[0], 1'b1, 2'b01} : {i[0], 1'b0, ~i[0], i[0]};
			cyc(6);
			chk("sdo", 9, {14'h0000,
				!(config_select_n && data_select_n) && (config_select_n ? queue_read_bit : config_read_bit),
				!(config_select_n && data_select_n)});
		end
		config_select_n = 1'b1; data_select_n = 1'b1;
		$display("test sdo done");
		chip_level_mode = 3'h4;
		data_pin_i = 1'b1; cyc(6); chk("tx_bit", 11, 16'h0001);
		data_pin_i = 1'b0; cyc(6); chk("tx_bit", 11, 16'h0000);
		chip_level_mode = 3'h3; pattern_detect_enable = 1'b1; run = 1'b1;
		cyc(300);
		chk("recovered", 12, 16'h0003);
		run = 1'b0; recovery_disable = 1'b1; cyc(12);
		chk("raw_pass", 10, {15'h0000, raw_bit});
		onoff_select = 1'b1;
		for (int i = 0; i < 6; i++) begin
			onoff_threshold_mode = om_tab[i];
			signal_strength_value = ss_tab[i];
			cyc(8);
			chk("onoff_bit", 10, {15'h0000, ob_tab[i]});
		end
		data_handling_mode = 2'h1;
		cyc(4);
		chk("buffered_pins", 10, 16'h0006);
		$display("test receive done");
		cyc(1);
		results();
	end
endmodule : radio_mode_synth_control_tb
`default_nettype wire
